// ---- cipm_pkg.sv ----
/*
  Shared definitions of the channel input mapper: register offsets, control
  layout, reset values and the load sizes of each sample format.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package cipm_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int NUM_CHANNELS = 4;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LOAD_CH0 = 8'h10;
  localparam logic [7:0] OFF_LOAD_CH3 = 8'h1c;

  // Status field positions.
  localparam int STATUS_ENABLE_BIT = 0;
  localparam int STATUS_ILLEGAL_BIT = 1;
  localparam int STATUS_COUNT_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus widths selected by bus_width_select.
  typedef enum logic [1:0] {
    BW_4 = 2'b00,
    BW_8 = 2'b01,
    BW_16 = 2'b10,
    BW_32 = 2'b11
  } cipm_bw_type;

  // Control register, bits 5:0, MSB first.
  typedef struct packed {
    logic enable;
    logic differential;
    logic wide16;
    logic complex;
    cipm_bw_type bus_width_select;
  } cipm_ctrl_type;

  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Bits per four-channel load and the narrowest bus.
  localparam logic [7:0] BASE_BUS_BITS = 8'h04;
  localparam logic [7:0] REAL_LOAD_BITS = 8'h20;
  localparam logic [7:0] CPLX8_LOAD_BITS = 8'h40;
  localparam logic [7:0] CPLX16_LOAD_BITS = 8'h80;
  localparam logic [7:0] ASSEMBLY_BITS = 8'h80;

  typedef struct packed {
    logic [15:0] q;
    logic [15:0] i;
  } cipm_chan_type;

  typedef cipm_chan_type [NUM_CHANNELS-1:0] cipm_load_type;

endpackage

// ---- cipm_mapper.sv ----
/*
  Channel input mapper: captures words from the parallel sample bus on the
  data strobe clock, assembles four-channel loads and hands each complete
  load to the aclk domain, where it is released together.
  Assumes the strobe runs continuously while streaming, that its period is
  longer than three aclk periods, and that control is changed only while the
  block is disabled.
*/
`timescale 1ns/1ns
`default_nettype none
module cipm_mapper
  import cipm_pkg::*;
(
  // Register bus clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Parallel sample bus from the source
  input wire logic data_strobe_clock,
  input wire logic [31:0] data_in,
  input wire logic frame_start,
  // Assembled loads toward the datapath
  output logic load_valid,
  output cipm_load_type load
);

  function automatic logic [7:0] bus_bits(input cipm_bw_type bw);
    return BASE_BUS_BITS << bw;
  endfunction

  function automatic logic [7:0] load_bits(input cipm_ctrl_type c);
    if (!c.complex) begin
      return REAL_LOAD_BITS;
    end
    return c.wide16 ? CPLX16_LOAD_BITS : CPLX8_LOAD_BITS;
  endfunction

  function automatic logic cfg_legal(input cipm_ctrl_type c);
    return !(c.wide16 && (!c.complex || c.bus_width_select == BW_4));
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  function automatic cipm_load_type decode_load(input logic [127:0] v,
                                                input cipm_ctrl_type c);
    cipm_load_type r;
    r = '0;
    for (int n = 0; n < NUM_CHANNELS; n++) begin
      if (!c.complex) begin
        r[n].i = sext8(v[8*n +: 8]);
      end else if (!c.wide16) begin
        r[n].i = sext8(v[16*n +: 8]);
        r[n].q = sext8(v[16*n+8 +: 8]);
      end else begin
        r[n].i = v[32*n +: 16];
        r[n].q = v[32*n+16 +: 16];
      end
    end
    return r;
  endfunction

  // ---- Register bus side ----
  cipm_ctrl_type ctrl, next_ctrl;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [AXI_ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0] wr_strb, next_wr_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [15:0] load_count, next_load_count;
  logic next_load_valid;
  cipm_load_type next_load;
  logic tog_meta, tog_sync, tog_seen;
  logic link_toggle, next_link_toggle;
  logic [127:0] hold;
  logic [AXI_ADDR_W-1:0] rd_index;

  assign rd_index = (s_axi_araddr - OFF_LOAD_CH0) >> 2;

  always_comb begin
    next_ctrl = ctrl;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awready = 1'b0;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wready = 1'b0;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    // Both halves held: apply the write and answer once.
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_SLVERR;
      if (wr_addr == OFF_CTRL) begin
        next_bresp = RESP_OKAY;
        if (wr_strb[0]) begin
          next_ctrl = cipm_ctrl_type'(wr_data[5:0]);
        end
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      if (s_axi_araddr == OFF_CTRL) begin
        next_rdata[5:0] = ctrl;
      end else if (s_axi_araddr == OFF_STATUS) begin
        next_rdata[STATUS_ENABLE_BIT] = ctrl.enable;
        next_rdata[STATUS_ILLEGAL_BIT] = !cfg_legal(ctrl);
        next_rdata[STATUS_COUNT_LSB +: 16] = load_count;
      end else if (s_axi_araddr >= OFF_LOAD_CH0 && s_axi_araddr <= OFF_LOAD_CH3
                   && s_axi_araddr[1:0] == 2'b00) begin
        next_rdata = load[rd_index[1:0]];
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Release of a completed load in the aclk domain.
  always_comb begin
    next_load_valid = 1'b0;
    next_load = load;
    next_load_count = load_count;
    if (tog_sync != tog_seen) begin
      next_load_valid = 1'b1;
      next_load = decode_load(hold, ctrl);
      next_load_count = load_count + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    tog_meta <= link_toggle;
    tog_sync <= tog_meta;
    if (!aresetn) begin
      ctrl <= cipm_ctrl_type'(CTRL_RESET);
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      // A toggle left standing by the stopped strobe must not release a load.
      tog_seen <= tog_sync;
      load_valid <= 1'b0;
      load <= '0;
      load_count <= '0;
    end else begin
      ctrl <= next_ctrl;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      tog_seen <= tog_sync;
      load_valid <= next_load_valid;
      load <= next_load;
      load_count <= next_load_count;
    end
  end

  // ---- Link side, on the data strobe clock ----
  logic rst_meta, link_resetn;
  cipm_ctrl_type cfg_meta, cfg;
  logic [31:0] cap_word;
  logic cap_frame;
  logic [15:0] fall_half;
  logic [4:0] load_cycle_index, next_load_cycle_index;
  logic [127:0] asm_buf, next_asm_buf, next_hold;
  logic [31:0] word;
  logic [7:0] width;
  logic [7:0] cycles;
  logic [4:0] cur;

  // Reset and control are levels; each crosses through two flip-flops.
  always_ff @(posedge data_strobe_clock) begin
    rst_meta <= aresetn;
    link_resetn <= rst_meta;
    cfg_meta <= ctrl;
    cfg <= cfg_meta;
  end

  // Pin capture: every word on the rising edge, upper half on the falling.
  always_ff @(posedge data_strobe_clock) begin
    cap_word <= data_in;
    cap_frame <= frame_start;
  end

  always_ff @(negedge data_strobe_clock) begin
    fall_half <= data_in[15:0];
  end

  always_comb begin
    width = bus_bits(cfg.bus_width_select);
    cycles = load_bits(cfg) >> ({1'b0, cfg.bus_width_select} + 3'd2);
    // Double rate pairs the rising half below the falling half of one period.
    if (cfg.differential && cfg.bus_width_select == BW_32) begin
      word = {fall_half, cap_word[15:0]};
    end else begin
      word = cap_word & (32'hffff_ffff >> (8'h20 - width));
    end
    // Words enter at the top and move down, so the first word ends lowest.
    next_asm_buf = (asm_buf >> width)
                   | ({96'h0, word} << (ASSEMBLY_BITS - width));
    next_hold = hold;
    next_link_toggle = link_toggle;
    next_load_cycle_index = load_cycle_index;
    cur = cap_frame ? 5'd0 : load_cycle_index;
    if (!cfg.enable || !cfg_legal(cfg)) begin
      next_load_cycle_index = 5'd0;
    end else if (cur == 5'(cycles - 8'h01)) begin
      // Loads land low-first: channel 0 first, I before Q, low part first.
      next_load_cycle_index = 5'd0;
      next_hold = next_asm_buf >> (ASSEMBLY_BITS - load_bits(cfg));
      next_link_toggle = !link_toggle;
    end else begin
      next_load_cycle_index = cur + 5'd1;
    end
  end

  always_ff @(posedge data_strobe_clock) begin
    if (!link_resetn) begin
      load_cycle_index <= 5'd0;
      asm_buf <= '0;
      hold <= '0;
      link_toggle <= 1'b0;
    end else begin
      load_cycle_index <= next_load_cycle_index;
      asm_buf <= next_asm_buf;
      hold <= next_hold;
      link_toggle <= next_link_toggle;
    end
  end

endmodule
`default_nettype wire

// ---- cipm_mapper_props.sv ----
/*
  Checker of the channel input mapper's bus handshakes and load release.
  Assumes it is bound to cipm_mapper and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module cipm_mapper_props
  import cipm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loads
  input wire logic load_valid,
  input wire cipm_load_type load
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_load_pulse: assert property (load_valid |=> !load_valid)
    else $error("load_valid longer than one cycle");
  a_load_gap: assert property (load_valid |=> !load_valid [*5])
    else $error("loads closer than one strobe period");
  a_load_hold: assert property (!load_valid |-> $stable(load))
    else $error("load changed without load_valid");
  a_wr_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##[0:1] s_axi_awready)
    else $error("write channel not released");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read channel not released");
endmodule

bind cipm_mapper cipm_mapper_props i_cipm_mapper_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .load_valid, .load);
`default_nettype wire

// ---- cipm_source_model.sv ----
/*
  Behavioural sample source: sends one frame of words low part first.
  Assumes a 125 ns strobe that runs only within a frame.
*/
`timescale 1ns/1ns
`default_nettype none
module cipm_source_model (
  // Frame request
  input wire logic go,
  input wire logic [127:0] stream,
  input wire logic [7:0] n_words,
  input wire logic [5:0] wbits,
  input wire logic ddr,
  // Sample bus
  output logic strobe,
  output logic [31:0] data,
  output logic fs,
  output logic done
);
  logic [31:0] w;
  logic [31:0] m;
  initial begin
    strobe = 0;
    data = 0;
    fs = 0;
    done = 0;
  end
  // One extra strobe edge after the last word lets the load complete.
  always @(posedge go) begin
    m = (wbits == 6'd32) ? 32'hffff_ffff : (32'h1 << wbits) - 1;
    // Two idle edges first carry the new control setting across.
    repeat (2) begin
      #31 strobe = 1;
      #62 strobe = 0;
      #32;
    end
    for (int i = 0; i <= n_words; i++) begin
      w = (i < n_words) ? 32'(stream >> (i * wbits)) : ~w;
      data = ddr ? {16'(~i), w[15:0]} : (w & m) | (~m & {8{4'(i)}});
      fs = (i == 0);
      #31 strobe = 1;
      #31 if (ddr) data = {16'(i), w[31:16]};
      #31 strobe = 0;
      #32;
    end
    data = ~data;
    fs = 0;
    done = ~done;
  end
endmodule
`default_nettype wire

// ---- cipm_mapper_tb.sv ----
/*
  Self-checking bench of the channel input mapper over every legal format except double-rate 8-bit complex.
  Assumes the source model as far side and AXI4-Lite access to registers.
*/
`timescale 1ns/1ns
`default_nettype none
module cipm_mapper_tb
  import cipm_pkg::*;
;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, data_in, d, st;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, data_strobe_clock, frame_start, load_valid, done, go = 0, ddr = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] n_words = 8'd7;
  logic [5:0] wbits = 6'd4;
  logic [127:0] stream = 128'h8a7b_6c5d_4e3f_2011_f2e3_d4c5_b6a7_9881;
  cipm_load_type load, last_load, exp_load;
  int n_loads = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [5:0] rows [15] = '{6'h20, 6'h24, 6'h21, 6'h25, 6'h2d, 6'h22, 6'h26, 6'h2e,
    6'h23, 6'h27, 6'h2f, 6'h30, 6'h36, 6'h33, 6'h3f};

  cipm_mapper i_cipm_mapper (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_strobe_clock,
    .data_in, .frame_start, .load_valid, .load);
  cipm_source_model i_cipm_source_model (.go, .stream, .n_words, .wbits, .ddr,
    .strobe(data_strobe_clock), .data(data_in), .fs(frame_start), .done);

  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (load_valid === 1'b1) begin
      last_load <= load;
      n_loads <= n_loads + 1;
    end
  end

  task automatic close_out;
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // Sign-extends 8-bit terms; stream holds I0,Q0,I1.. or R0,R1.. low first.
  function automatic cipm_load_type expect_load(input logic [5:0] c);
    cipm_load_type e;
    for (int n = 0; n < 4; n++) begin
      if (!c[2]) e[n] = {16'h0000, {8{stream[8*n+7]}}, stream[8*n +: 8]};
      else if (!c[3]) e[n] = {{8{stream[16*n+15]}}, stream[16*n+8 +: 8],
        {8{stream[16*n+7]}}, stream[16*n +: 8]};
      else e[n] = stream[32*n +: 32];
    end
    return e;
  endfunction

  task automatic frame(input logic [5:0] c);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CTRL, {26'h0, c});
    wbits = 6'd4 << c[1:0];
    ddr = c[4] && c[1:0] == 2'b11;
    n_words = (c[2] ? (c[3] ? 8'd128 : 8'd64) : 8'd32) / wbits;
    go <= 1;
    @(done);
    go <= 0;
    repeat (10) @(posedge aclk);
  endtask

  initial begin
    // A disabled flush frame gives the strobe domain edges to see reset by.
    go <= 1;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(done);
    go <= 0;
    @(posedge aclk);
    rd(OFF_CTRL);
    chk("ctrl reset", 0, d);
    foreach (rows[k]) begin
      frame(rows[k]);
      exp_load = expect_load(rows[k]);
      chk("load", exp_load, last_load);
      rd(OFF_LOAD_CH3);
      chk("load ch3 reg", exp_load[3], d);
    end
    rd(OFF_STATUS);
    st = d;
    chk("load count", 16'(n_loads), st[31:16]);
    frame(6'h28);
    rd(OFF_STATUS);
    chk("illegal status", {st[31:16], 16'h0003}, d);
    rd(8'h08);
    chk("unmapped read", RESP_SLVERR, r);
    wr(OFF_STATUS, 32'h0000_0001);
    chk("read-only write", RESP_SLVERR, r);
    aresetn <= 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_CTRL);
    chk("ctrl after reset", 0, d);
    rd(OFF_STATUS);
    chk("status after reset", 0, d);
    close_out;
  end

  initial begin
    #300_000;
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
